// ---- verilog/thc_pkg.sv ----
// Shared constants for the threshold comparator with hysteresis
`default_nettype none

package thc_pkg;

    // ************************************************************
    // Widths
    // ************************************************************
    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;
    localparam int IRQ_W  = 4;
    localparam int CONN_W = 4;

    // ************************************************************
    // Register byte offsets
    // ************************************************************
    localparam logic [7:0] OFS_CTRL       = 8'h00;
    localparam logic [7:0] OFS_STATUS     = 8'h08;
    localparam logic [7:0] OFS_ACTUAL     = 8'h0c;
    localparam logic [7:0] OFS_SETPOINT   = 8'h10;
    localparam logic [7:0] OFS_ACT_GAIN   = 8'h14;
    localparam logic [7:0] OFS_SET_GAIN   = 8'h18;
    localparam logic [7:0] OFS_ZERO_SHIFT = 8'h1c;
    localparam logic [7:0] OFS_MARGIN     = 8'h20;
    localparam logic [7:0] OFS_IRQ_STAT   = 8'h24;
    localparam logic [7:0] OFS_IRQ_MASK   = 8'h28;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int CTRL_MODE_LSB  = 0;
    localparam int CTRL_AUTO_BIT  = 2;
    localparam int CTRL_CONN_LSB  = 4;
    localparam int CTRL_START_BIT = 8;
    localparam int STAT_RES_BIT   = 0;
    localparam int STAT_OVF_BIT   = 1;
    localparam int STAT_BUSY_BIT  = 2;
    localparam int CONN_AGAIN     = 0;
    localparam int CONN_SGAIN     = 1;
    localparam int CONN_SHIFT     = 2;
    localparam int CONN_MARGIN    = 3;
    localparam int IRQ_DONE       = 0;
    localparam int IRQ_RISE       = 1;
    localparam int IRQ_FALL       = 2;
    localparam int IRQ_OVF        = 3;

    // ************************************************************
    // Comparison modes
    // ************************************************************
    localparam logic [1:0] BELOW_MODE = 2'h0;
    localparam logic [1:0] ABOVE_MODE = 2'h1;
    localparam logic [1:0] MATCH_MODE = 2'h2;

    // ************************************************************
    // Reset and default values
    // ************************************************************
    localparam logic [1:0]  RST_MODE    = BELOW_MODE;
    localparam logic [3:0]  RST_CONN    = 4'h0;
    localparam logic [3:0]  RST_MASK    = 4'h0;
    localparam logic [31:0] RST_GAIN    = 32'h1;
    localparam logic [31:0] DFLT_GAIN   = 32'h1;
    localparam logic [31:0] DFLT_SHIFT  = 32'h0;
    localparam logic [31:0] DFLT_MARGIN = 32'h0;

    // Signed 32-bit limits at the width of the checked sums
    localparam logic signed [65:0] LIM_HI = 66'sh7fffffff;
    localparam logic signed [65:0] LIM_LO = -LIM_HI - 66'sh1;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int EVAL_TIME_NS = 96000;
    localparam int CLK_FREQ_MHZ = 200;
    localparam int SCAN_CYC     = (EVAL_TIME_NS * CLK_FREQ_MHZ) / 1000;

endpackage : thc_pkg

`default_nettype wire

// ---- verilog/thc_scale.sv ----
// Registered signed multiply-add stage: a * b + c at full width
`timescale 1ns/1ps
`default_nettype none

module thc_scale (
    input  wire logic               i_clk,   // System clock
    input  wire logic               i_rstn,  // Async reset, active low
    input  wire logic               i_ce,    // Clock enable
    input  wire logic signed [31:0] i_mul_a, // Operand
    input  wire logic signed [31:0] i_mul_b, // Gain factor
    input  wire logic signed [31:0] i_add,   // Added term
    output logic signed [64:0]      o_sum    // Exact result
);

    typedef struct packed {
        logic signed [64:0] sum;
    } thc_scale_state_type;

    thc_scale_state_type q;
    thc_scale_state_type d;

    always_comb
    begin
        logic signed [63:0] prod;
        prod  = i_mul_a * i_mul_b;
        // Kept one bit wider so range checks see the true value
        d.sum = {prod[63], prod} + {{33{i_add[31]}}, i_add};
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            q <= '0;
        end
        else if (i_ce)
        begin
            q <= d;
        end
    end

    assign o_sum = q.sum;

endmodule : thc_scale

`default_nettype wire

// ---- verilog/thc_compare.sv ----
// Threshold comparator with hysteresis, APB registers and interrupt
//
// Operation
// RULE1 - Three modes: above, match, below
// RULE2 - Mode defaults to below after reset
// RULE3 - Each operand scaled by its own gain
// RULE4 - Signed zero shift added to scaled actual
// RULE5 - One margin sets symmetric band around setpoint
// RULE6 - Unconnected: gains one, shift and margin zero
// RULE7 - Overflow if a checked sum leaves 32 bits
// RULE8 - Overflow forces result contact to zero
// RULE9 - Above: close at setpoint, open below band
// RULE10 - Below: close at setpoint, open above band
// RULE11 - Match: close when equal, open outside band
// RULE12 - Evaluation completes within 96 us
// RULE13 - All operands signed 32-bit integers
// RULE14 - Result registered per strobe, held inside band
//
// Our own choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module thc_compare #(
    parameter int P_SCAN_CYC = thc_pkg::SCAN_CYC // Cycles per automatic scan
) (
    input  wire logic        i_clk,            // 200 MHz clock
    input  wire logic        i_rstn,           // Async reset, active low
    input  wire logic        i_ce,             // Clock enable, freezes all state
    input  wire logic        i_eval_stb,       // Evaluation request pulse
    input  wire logic        i_psel,           // APB select
    input  wire logic        i_penable,        // APB enable
    input  wire logic        i_pwrite,         // APB direction
    input  wire logic [7:0]  i_paddr,          // APB byte address
    input  wire logic [31:0] i_pwdata,         // APB write data
    output logic      [31:0] o_prdata,         // APB read data
    output logic             o_pready,         // APB ready
    output logic             o_pslverr,        // APB error
    output logic             o_compare_result, // Result contact
    output logic             o_range_overflow, // Range overflow flag
    output logic             o_eval_done,      // Evaluation finished pulse
    output logic             o_irq             // Interrupt, level
);

    localparam int SCAN_W = $clog2(P_SCAN_CYC + 1);

    // ************************************************************
    // State
    // ************************************************************
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SCALE,
        ST_CHECK
    } thc_st_type;

    typedef struct packed {
        thc_st_type         st;
        logic [1:0]         mode;
        logic               autorun;
        logic [3:0]         conn;
        logic signed [31:0] act;
        logic signed [31:0] sp;
        logic signed [31:0] g1;
        logic signed [31:0] g2;
        logic signed [31:0] os;
        logic signed [31:0] hy;
        logic [3:0]         ist;
        logic [3:0]         imask;
        logic               result;
        logic               ovf;
        logic               irq;
        logic               done;
        logic               pready;
        logic               pslverr;
        logic [31:0]        prdata;
        logic [SCAN_W-1:0]  scan;
    } thc_state_type;

    localparam thc_state_type Q_RST = '{
        st:      ST_IDLE,
        mode:    thc_pkg::RST_MODE,
        conn:    thc_pkg::RST_CONN,
        imask:   thc_pkg::RST_MASK,
        g1:      thc_pkg::RST_GAIN,
        g2:      thc_pkg::RST_GAIN,
        default: '0
    };

    thc_state_type q;
    thc_state_type d;

    logic signed [31:0] act_gain;
    logic signed [31:0] sp_gain;
    logic signed [31:0] shift;
    logic signed [31:0] margin;
    logic signed [64:0] act_sum;
    logic signed [64:0] sp_sum;

    // ************************************************************
    // Operand selection
    // ************************************************************
    assign act_gain = q.conn[thc_pkg::CONN_AGAIN] ? q.g1 : thc_pkg::DFLT_GAIN;  // [RULE6]
    assign sp_gain  = q.conn[thc_pkg::CONN_SGAIN] ? q.g2 : thc_pkg::DFLT_GAIN;  // [RULE6]
    assign shift    = q.conn[thc_pkg::CONN_SHIFT] ? q.os : thc_pkg::DFLT_SHIFT; // [RULE6]
    assign margin   = q.conn[thc_pkg::CONN_MARGIN] ? q.hy : thc_pkg::DFLT_MARGIN; // [RULE6]

    // ************************************************************
    // Scaling
    // ************************************************************
    // Actual value times its gain plus zero shift
    thc_scale u_act_scale (
        .i_clk   (i_clk),
        .i_rstn  (i_rstn),
        .i_ce    (i_ce),
        .i_mul_a (q.act),     // [RULE3]
        .i_mul_b (act_gain),  // [RULE3]
        .i_add   (shift),     // [RULE4]
        .o_sum   (act_sum)
    );

    // Setpoint times its gain
    thc_scale u_sp_scale (
        .i_clk   (i_clk),
        .i_rstn  (i_rstn),
        .i_ce    (i_ce),
        .i_mul_a (q.sp),      // [RULE3]
        .i_mul_b (sp_gain),   // [RULE3]
        .i_add   (thc_pkg::DFLT_SHIFT),
        .o_sum   (sp_sum)
    );

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb
    begin
        logic               acc;
        logic               hit;
        logic               start;
        logic               tick;
        logic [3:0]         ev;
        logic [3:0]         clr;
        logic signed [65:0] x;
        logic signed [65:0] s;
        logic signed [65:0] hi;
        logic signed [65:0] lo;
        logic               ovf;
        logic               res;

        d        = q;
        acc      = i_psel & i_penable & ~q.pready;
        hit      = 1'b1;
        start    = 1'b0;
        tick     = 1'b0;
        ev       = '0;
        clr      = '0;
        x        = {act_sum[64], act_sum};
        s        = {sp_sum[64], sp_sum};
        hi       = s + {{34{margin[31]}}, margin}; // [RULE5]
        lo       = s - {{34{margin[31]}}, margin}; // [RULE5]
        ovf      = 1'b0;
        res      = q.result;
        d.done   = 1'b0;
        d.pready = acc;
        d.pslverr = 1'b0;

        // ********************************************************
        // Register access
        // ********************************************************
        if (acc)
        begin
            d.prdata = '0;
            case (i_paddr)
                thc_pkg::OFS_CTRL:
                begin
                    d.prdata = {24'h0, q.conn, 1'b0, q.autorun, q.mode};
                    if (i_pwrite)
                    begin
                        d.mode    = i_pwdata[thc_pkg::CTRL_MODE_LSB +: 2];
                        d.autorun = i_pwdata[thc_pkg::CTRL_AUTO_BIT];
                        d.conn    = i_pwdata[thc_pkg::CTRL_CONN_LSB +: thc_pkg::CONN_W];
                        start     = i_pwdata[thc_pkg::CTRL_START_BIT];
                    end
                end
                thc_pkg::OFS_STATUS:
                begin
                    d.prdata[thc_pkg::STAT_RES_BIT]  = q.result;
                    d.prdata[thc_pkg::STAT_OVF_BIT]  = q.ovf;
                    d.prdata[thc_pkg::STAT_BUSY_BIT] = (q.st != ST_IDLE);
                end
                thc_pkg::OFS_ACTUAL:
                begin
                    d.prdata = q.act;
                    if (i_pwrite)
                    begin
                        d.act = i_pwdata; // [RULE13]
                    end
                end
                thc_pkg::OFS_SETPOINT:
                begin
                    d.prdata = q.sp;
                    if (i_pwrite)
                    begin
                        d.sp = i_pwdata; // [RULE13]
                    end
                end
                thc_pkg::OFS_ACT_GAIN:
                begin
                    d.prdata = q.g1;
                    if (i_pwrite)
                    begin
                        d.g1 = i_pwdata;
                    end
                end
                thc_pkg::OFS_SET_GAIN:
                begin
                    d.prdata = q.g2;
                    if (i_pwrite)
                    begin
                        d.g2 = i_pwdata;
                    end
                end
                thc_pkg::OFS_ZERO_SHIFT:
                begin
                    d.prdata = q.os;
                    if (i_pwrite)
                    begin
                        d.os = i_pwdata;
                    end
                end
                thc_pkg::OFS_MARGIN:
                begin
                    d.prdata = q.hy;
                    if (i_pwrite)
                    begin
                        d.hy = i_pwdata;
                    end
                end
                thc_pkg::OFS_IRQ_STAT:
                begin
                    d.prdata = {28'h0, q.ist};
                    if (!i_pwrite)
                    begin
                        clr = q.ist;
                    end
                end
                thc_pkg::OFS_IRQ_MASK:
                begin
                    d.prdata = {28'h0, q.imask};
                    if (i_pwrite)
                    begin
                        d.imask = i_pwdata[3:0];
                    end
                end
                default:
                begin
                    hit = 1'b0;
                end
            endcase
            d.pslverr = ~hit;
        end

        // ********************************************************
        // Scan timer
        // ********************************************************
        // One evaluation per scan period keeps each result within budget
        if (q.autorun)
        begin
            if (q.scan == SCAN_W'(P_SCAN_CYC - 1))
            begin
                tick   = 1'b1; // [RULE12]
                d.scan = '0;
            end
            else
            begin
                d.scan = q.scan + SCAN_W'(1);
            end
        end
        else
        begin
            d.scan = '0;
        end

        // ********************************************************
        // Evaluation
        // ********************************************************
        // Requests arriving while busy are dropped, not queued
        case (q.st)
            ST_IDLE:
            begin
                if (start | tick | i_eval_stb)
                begin
                    d.st = ST_SCALE;
                end
            end
            ST_SCALE:
            begin
                d.st = ST_CHECK;
            end
            ST_CHECK:
            begin
                ovf = (x < thc_pkg::LIM_LO) | (x > thc_pkg::LIM_HI)      // [RULE7]
                    | (hi < thc_pkg::LIM_LO) | (hi > thc_pkg::LIM_HI)    // [RULE7]
                    | (lo < thc_pkg::LIM_LO) | (lo > thc_pkg::LIM_HI);   // [RULE7]
                case (q.mode)                                            // [RULE1]
                    thc_pkg::ABOVE_MODE:
                    begin
                        if (x >= s)
                        begin
                            res = 1'b1;      // [RULE9]
                        end
                        else if (x < lo)
                        begin
                            res = 1'b0;      // [RULE9]
                        end
                    end
                    thc_pkg::MATCH_MODE:
                    begin
                        if (x == s)
                        begin
                            res = 1'b1;      // [RULE11]
                        end
                        else if ((x > hi) || (x < lo))
                        begin
                            res = 1'b0;      // [RULE11]
                        end
                    end
                    default:
                    begin
                        // Unconfigured code also compares as below
                        if (x <= s)
                        begin
                            res = 1'b1;      // [RULE2] [RULE10]
                        end
                        else if (x > hi)
                        begin
                            res = 1'b0;      // [RULE10]
                        end
                    end
                endcase
                if (ovf)
                begin
                    res = 1'b0;              // [RULE8]
                end
                d.result = res;              // [RULE14]
                d.ovf    = ovf;
                d.done   = 1'b1;
                d.st     = ST_IDLE;
                ev[thc_pkg::IRQ_DONE] = 1'b1;
                ev[thc_pkg::IRQ_RISE] = res & ~q.result;
                ev[thc_pkg::IRQ_FALL] = ~res & q.result;
                ev[thc_pkg::IRQ_OVF]  = ovf;
            end
            default:
            begin
                d.st = ST_IDLE;
            end
        endcase

        // ********************************************************
        // Interrupt
        // ********************************************************
        // New events win over a read-clear in the same cycle
        d.ist = (q.ist & ~clr) | ev;
        d.irq = |(d.ist & d.imask);
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            q <= Q_RST; // [RULE2] [RULE14]
        end
        else if (i_ce)
        begin
            q <= d;
        end
    end

    assign o_prdata         = q.prdata;
    assign o_pready         = q.pready;
    assign o_pslverr        = q.pslverr;
    assign o_compare_result = q.result;
    assign o_range_overflow = q.ovf;
    assign o_eval_done      = q.done;
    assign o_irq            = q.irq;

endmodule : thc_compare

`default_nettype wire

// ---- verif/thc_compare_properties.sv ----
// Port-level assertions for the threshold comparator
`timescale 1ns/1ps
`default_nettype none

module thc_props #(
    parameter int P_SCAN_CYC = 8 // Auto-scan period in cycles
) (
    input wire logic       i_clk,            // System clock
    input wire logic       i_rstn,           // Async reset, active low
    input wire logic       i_ce,             // Clock enable
    input wire logic       i_eval_stb,       // Evaluation request
    input wire logic       i_psel,           // APB select
    input wire logic       i_penable,        // APB enable
    input wire logic [7:0] i_paddr,          // APB address
    input wire logic       o_pready,         // APB ready
    input wire logic       o_pslverr,        // APB error
    input wire logic       o_compare_result, // Result contact
    input wire logic       o_range_overflow, // Overflow flag
    input wire logic       o_eval_done       // Evaluation finished
);
    // ********************
    // Properties
    // ********************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    property p_rdy_lat;
        i_ce && i_psel && i_penable && !o_pready |=> o_pready;
    endproperty
    a_rdy_lat: assert property (p_rdy_lat) else $error("pready missing");

    property p_rdy_one;
        o_pready |=> !o_pready;
    endproperty
    a_rdy_one: assert property (p_rdy_one) else $error("pready too long");

    property p_err_map;
        i_psel && i_penable && !o_pready && i_paddr == 8'h04 |=> o_pslverr && o_pready;
    endproperty
    a_err_map: assert property (p_err_map) else $error("unmapped not refused");

    property p_ovf_res;
        o_range_overflow |-> !o_compare_result;
    endproperty
    a_ovf_res: assert property (p_ovf_res) else $error("contact closed on overflow");

    property p_res_chg;
        !$stable(o_compare_result) |-> o_eval_done;
    endproperty
    a_res_chg: assert property (p_res_chg) else $error("contact moved off strobe");

    property p_ovf_chg;
        !$stable(o_range_overflow) |-> o_eval_done;
    endproperty
    a_ovf_chg: assert property (p_ovf_chg) else $error("overflow moved off strobe");

    property p_eval;
        i_ce && i_eval_stb |-> ##[1:3] o_eval_done;
    endproperty
    a_eval: assert property (p_eval) else $error("evaluation too slow");

    property p_done_gap;
        o_eval_done |=> !o_eval_done [*2];
    endproperty
    a_done_gap: assert property (p_done_gap) else $error("done pulses too close");

    c_ovf: cover property (o_range_overflow && o_eval_done);
    c_err: cover property (o_pslverr);
    c_rise: cover property ($rose(o_compare_result));
endmodule : thc_props

`default_nettype wire

// ---- verif/thc_scan_src.sv ----
// Program-logic model: issues evaluation strobes and counts finished scans
`timescale 1ns/1ps
`default_nettype none

module thc_scan_src (
    input  wire logic i_clk,   // System clock
    input  wire logic i_rstn,  // Async reset, active low
    input  wire logic i_kick,  // One strobe per cycle held
    input  wire logic i_done,  // Evaluation finished pulse
    output var logic  o_stb,   // Strobe to the comparator
    output var int    o_dones  // Finished evaluations seen
);
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_stb   <= 1'b0;
            o_dones <= 0;
        end
        else
        begin
            o_stb   <= i_kick;
            o_dones <= o_dones + int'(i_done);
        end
    end
endmodule : thc_scan_src

`default_nettype wire

// ---- verif/test_thc_compare.sv ----
// Self-checking bench for the threshold comparator
`timescale 1ns/1ps
`default_nettype none

module test_thc_compare;
    logic        clk    = 1'b0;
    logic        rstn   = 1'b0;
    logic        ce     = 1'b1;
    logic        kick   = 1'b0;
    logic        psel   = 1'b0;
    logic        pen    = 1'b0;
    logic        pwr    = 1'b0;
    logic [7:0]  paddr  = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] rdat;
    logic        stb, pready, pslverr, res, ovf, done, irq, err;
    int          dones, base;
    int          mismatches = 0;
    int          compares   = 0;

    always #2.5 clk = ~clk;

    thc_compare #(.P_SCAN_CYC(8)) DUT (
        .i_clk(clk), .i_rstn(rstn), .i_ce(ce), .i_eval_stb(stb), .i_psel(psel),
        .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .o_compare_result(res), .o_range_overflow(ovf), .o_eval_done(done), .o_irq(irq));

    thc_scan_src u_src (.i_clk(clk), .i_rstn(rstn), .i_kick(kick), .i_done(done),
                        .o_stb(stb), .o_dones(dones));

    // ********************
    // Tasks
    // ********************
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic results();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : results

    // Entered right after a rising edge; idles one cycle after each access
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel   <= 1'b1;
        pwr    <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        rdat = prdata;
        err  = pslverr;
        psel <= 1'b0;
        pen  <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask : rd

    task automatic ev(input logic [31:0] x, input logic r, input logic o);
        wr(thc_pkg::OFS_ACTUAL, x);
        kick <= 1'b1;
        @(posedge clk);
        kick <= 1'b0;
        do
            @(posedge clk);
        while (done !== 1'b1);
        chk("contact", 32'(res), 32'(r));
        chk("overflow", 32'(ovf), 32'(o));
        rd(thc_pkg::OFS_STATUS);
        chk("status", rdat, 32'({o, r}));
    endtask : ev

    // ********************
    // Sequence
    // ********************
    initial
    begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rd(thc_pkg::OFS_CTRL);
        chk("ctrl reset", rdat, 32'h0);
        rd(thc_pkg::OFS_SET_GAIN);
        chk("gain reset", rdat, 32'h1);
        rd(8'h04);
        chk("unmapped", {rdat[30:0], err}, 32'h1);
        wr(thc_pkg::OFS_SETPOINT, 32'd100);
        wr(thc_pkg::OFS_MARGIN, 32'd5);
        // Margin written but unconnected, so the band stays closed
        ev(32'd101, 1'b0, 1'b0);
        ev(32'd100, 1'b1, 1'b0);
        ev(32'd101, 1'b0, 1'b0);
        wr(thc_pkg::OFS_CTRL, 32'h80);
        ev(32'd100, 1'b1, 1'b0);
        ev(32'd105, 1'b1, 1'b0);
        ev(32'd106, 1'b0, 1'b0);
        wr(thc_pkg::OFS_CTRL, 32'h81);
        ev(32'd99, 1'b0, 1'b0);
        ev(32'd100, 1'b1, 1'b0);
        ev(32'd95, 1'b1, 1'b0);
        ev(32'd94, 1'b0, 1'b0);
        wr(thc_pkg::OFS_CTRL, 32'h82);
        ev(32'd100, 1'b1, 1'b0);
        ev(32'd105, 1'b1, 1'b0);
        ev(32'd106, 1'b0, 1'b0);
        ev(32'd103, 1'b0, 1'b0);
        ev(32'd100, 1'b1, 1'b0);
        ev(32'd94, 1'b0, 1'b0);
        wr(thc_pkg::OFS_CTRL, 32'h83);
        ev(32'd50, 1'b1, 1'b0);
        wr(thc_pkg::OFS_SETPOINT, 32'd12);
        wr(thc_pkg::OFS_ACT_GAIN, 32'd3);
        wr(thc_pkg::OFS_SET_GAIN, 32'd3);
        wr(thc_pkg::OFS_ZERO_SHIFT, 32'd5);
        wr(thc_pkg::OFS_CTRL, 32'h71);
        ev(32'd10, 1'b0, 1'b0);
        wr(thc_pkg::OFS_ZERO_SHIFT, 32'd6);
        ev(32'd10, 1'b1, 1'b0);
        wr(thc_pkg::OFS_CTRL, 32'h01);
        ev(32'd10, 1'b0, 1'b0);
        wr(thc_pkg::OFS_CTRL, 32'h11);
        ev(32'h2aaaaaaa, 1'b1, 1'b0);
        ev(32'h2aaaaaab, 1'b0, 1'b1);
        ev(32'hd5555556, 1'b0, 1'b0);
        ev(32'hd5555555, 1'b0, 1'b1);
        wr(thc_pkg::OFS_CTRL, 32'h41);
        ev(32'h7ffffff9, 1'b1, 1'b0);
        ev(32'h7ffffffa, 1'b0, 1'b1);
        wr(thc_pkg::OFS_CTRL, 32'h81);
        wr(thc_pkg::OFS_SETPOINT, 32'h7ffffffb);
        ev(32'd0, 1'b0, 1'b1);
        wr(thc_pkg::OFS_SETPOINT, 32'h80000004);
        ev(32'd0, 1'b0, 1'b1);
        wr(thc_pkg::OFS_SETPOINT, 32'h80000005);
        ev(32'd0, 1'b1, 1'b0);
        rd(thc_pkg::OFS_IRQ_STAT);
        chk("irq all", rdat, 32'hf);
        ev(32'd0, 1'b1, 1'b0);
        chk("irq masked", 32'(irq), 32'h0);
        wr(thc_pkg::OFS_IRQ_MASK, 32'h1);
        chk("irq level", 32'(irq), 32'h1);
        rd(thc_pkg::OFS_IRQ_STAT);
        chk("irq clear", {rdat[30:0], irq}, 32'h2);
        // Second strobe lands while busy and must be dropped
        base = dones;
        kick <= 1'b1;
        repeat (2) @(posedge clk);
        kick <= 1'b0;
        repeat (8) @(posedge clk);
        chk("busy drop", 32'(dones - base), 32'h1);
        base = dones;
        wr(thc_pkg::OFS_CTRL, 32'h181);
        repeat (4) @(posedge clk);
        chk("start bit", 32'(dones - base), 32'h1);
        wr(thc_pkg::OFS_CTRL, 32'h85);
        base = dones;
        repeat (80) @(posedge clk);
        wr(thc_pkg::OFS_CTRL, 32'h81);
        chk("scan rate", 32'(dones - base > 8 && dones - base < 12), 32'h1);
        // Strobes while the clock enable is low must leave no trace
        base = dones;
        ce   <= 1'b0;
        kick <= 1'b1;
        repeat (3) @(posedge clk);
        kick <= 1'b0;
        repeat (2) @(posedge clk);
        ce <= 1'b1;
        repeat (5) @(posedge clk);
        chk("ce freeze", 32'(dones - base), 32'h0);
        results();
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        mismatches++;
        results();
    end
endmodule : test_thc_compare

bind thc_compare thc_props #(.P_SCAN_CYC(P_SCAN_CYC)) u_props (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_ce(i_ce), .i_eval_stb(i_eval_stb), .i_psel(i_psel),
    .i_penable(i_penable), .i_paddr(i_paddr), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .o_compare_result(o_compare_result), .o_range_overflow(o_range_overflow),
    .o_eval_done(o_eval_done));

`default_nettype wire
